// file: pbc_regs.svh
`ifndef PBC_REGS_SVH
`define PBC_REGS_SVH

// ---------------------------------------------------------------
// register map and fields
// ---------------------------------------------------------------
`define PBC_REG_BASIC_CONTROL 5'h00
`define PBC_BIT_SRESET        15
`define PBC_BIT_LOOPBACK      14
`define PBC_BIT_SPEED         13
`define PBC_BIT_NEGOTIATION_HW_ENABLE_PIN         12
`define PBC_BIT_PDOWN         11
`define PBC_BIT_ISOLATE       10
`define PBC_BIT_RESTART       9
`define PBC_BIT_DUPLEX        8
`define PBC_BIT_COLTEST       7
`define PBC_RSVD_MSB          6
`define PBC_ISOLATE_ADDR      5'h00

// ---------------------------------------------------------------
// management frame layout
// ---------------------------------------------------------------
`define PBC_PREAMBLE_LEN      6'h20
`define PBC_HDR_BITS          5'h0D
`define PBC_TA_BITS           5'h02
`define PBC_DATA_BITS         5'h10
`define PBC_OP_WRITE          2'h1
`define PBC_OP_READ           2'h2

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PBC_CLK_NS            50
`define PBC_SRESET_NS         1000000
`define PBC_SRESET_CYCLES     (`PBC_SRESET_NS / `PBC_CLK_NS)
`define PBC_COL_OFF_NS        400
`define PBC_COL_OFF_CYCLES    (`PBC_COL_OFF_NS / `PBC_CLK_NS)
`endif

// file: pbc_pkg.sv
package pbc_pkg;
    // management frame receiver states
    typedef enum logic [1:0] {
        PBC_ST_IDLE,
        PBC_ST_HDR,
        PBC_ST_TA,
        PBC_ST_DATA
    } pbc_mdio_state_t;
    typedef logic [15:0] pbc_word_t;
endpackage

// file: pbc_mode_if.sv
`timescale 1ns/1ps
interface pbc_mode_if;
    logic sr_start;
    logic sr_busy;
    logic sr_done;
    logic loopback;
    logic col_test;
    logic col;
    modport ctrl   (output sr_start, output loopback, output col_test,
                    input sr_busy, input sr_done, input col);
    modport sreset (input sr_start, output sr_busy, output sr_done);
    modport coltst (input loopback, input col_test, output col);
endinterface

// file: pbc_soft_reset.sv
`timescale 1ns/1ps
`include "pbc_regs.svh"
module pbc_soft_reset
    import pbc_pkg::*;
#(
    parameter int SRESET_CYCLES = `PBC_SRESET_CYCLES
) (
    input  wire logic clk_sys_in,
    input  wire logic nrst_in,
    pbc_mode_if.sreset mode
);
    logic [15:0] cnt_ff;
    logic        busy_ff;
    wire         last = busy_ff && (cnt_ff == 16'(SRESET_CYCLES - 1));

    // busy from start until the count expires; restarts are ignored
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            busy_ff <= 1'b0;
            cnt_ff  <= 16'h0000;
        end else if (!busy_ff) begin
            busy_ff <= mode.sr_start;
            cnt_ff  <= 16'h0000;
        end else begin
            busy_ff <= !last;
            cnt_ff  <= cnt_ff + 16'h0001;
        end
    end

    assign mode.sr_busy = busy_ff;
    assign mode.sr_done = last;

    a_sreset_start: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !busy_ff && mode.sr_start |=> busy_ff && cnt_ff == 16'h0000)
        else $error("soft reset did not start");
    a_sreset_ends: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        last |=> !busy_ff)
        else $error("soft reset did not self-clear");
endmodule

// file: pbc_col_test.sv
`timescale 1ns/1ps
`include "pbc_regs.svh"
module pbc_col_test
    import pbc_pkg::*;
(
    input  wire logic clk_sys_in,
    input  wire logic nrst_in,
    input  wire logic tx_en_in,
    pbc_mode_if.coltst mode
);
    logic tx_meta_ff;
    logic tx_sync_ff;
    logic col_ff;
    // only counts while loop-back is also on
    wire  active = mode.col_test && mode.loopback;

    // transmit enable comes from the MAC clock, two flops first
    always_ff @(posedge clk_sys_in) begin
        tx_meta_ff <= tx_en_in;
        tx_sync_ff <= tx_meta_ff;
    end

    // three cycles pin to pin, well inside the 10 Mb/s off limit
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            col_ff <= 1'b0;
        end else begin
            col_ff <= active && tx_sync_ff;
        end
    end

    assign mode.col = col_ff;

    a_col_follows: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        active && tx_sync_ff |=> col_ff)
        else $error("collision not raised with transmit enable");
    a_col_drops: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !tx_sync_ff |=> !col_ff)
        else $error("collision not dropped after transmit enable");
    a_col_needs_loop: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !$past(active) |-> !col_ff)
        else $error("collision without loop-back test");
endmodule

// file: pbc_top.sv
`timescale 1ns/1ps
`include "pbc_regs.svh"
module pbc_top
    import pbc_pkg::*;
#(
    parameter int SRESET_CYCLES = `PBC_SRESET_CYCLES
) (
    input  wire logic       clk_sys_in,
    input  wire logic       nrst_in,
    input  wire logic       mdc_in,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe_out,
    input  wire logic [4:0] strap_phy_addr_in,
    input  wire logic       strap_loopback_in,
    input  wire logic       strap_speed_in,
    input  wire logic       strap_negotiation_hw_enable_pin_in,
    input  wire logic       strap_duplex_in,
    input  wire logic       fibre_mode_in,
    input  wire logic       negotiation_hw_enable_pin_in,
    input  wire logic       mii_tx_en_in,
    output logic            mii_col_out,
    output logic            speed_100_out,
    output logic            full_duplex_out,
    output logic            an_enable_out,
    output logic            an_restart_out,
    output logic            loopback_out,
    output logic            power_down_out,
    output logic            pad_dir_force_out,
    output logic            mii_out_en_out,
    output logic            mii_in_ignore_out,
    output logic            soft_reset_busy_out
);
    pbc_mode_if mode ();

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [9:0] pin_meta_ff;
    logic [9:0] pin_sync_ff;
    logic [1:0] mgmt_meta_ff;
    logic [1:0] mgmt_sync_ff;
    logic       mdc_prev_ff;

    // straps and mode pins: two flops before anything reads them
    always_ff @(posedge clk_sys_in) begin
        pin_meta_ff  <= {negotiation_hw_enable_pin_in, fibre_mode_in, strap_duplex_in,
                         strap_negotiation_hw_enable_pin_in, strap_speed_in, strap_loopback_in, strap_phy_addr_in[3:0]};
        pin_sync_ff  <= pin_meta_ff;
        mgmt_meta_ff <= {mdc_in, mdio_in};
        mgmt_sync_ff <= mgmt_meta_ff;
        mdc_prev_ff  <= mgmt_sync_ff[1];
    end

    logic addr4_meta_ff;
    logic addr4_sync_ff;
    always_ff @(posedge clk_sys_in) begin
        addr4_meta_ff <= strap_phy_addr_in[4];
        addr4_sync_ff <= addr4_meta_ff;
    end

    wire [4:0] phy_addr_pin = {addr4_sync_ff, pin_sync_ff[3:0]};
    wire       hw_an_pin    = pin_sync_ff[9];
    wire       fibre_pin    = pin_sync_ff[8];
    wire       mdc_rise     = mgmt_sync_ff[1] && !mdc_prev_ff;
    wire       mdio_bit     = mgmt_sync_ff[0];

    // ---------------------------------------------------------------
    // strap capture, once after chip reset
    // ---------------------------------------------------------------
    logic       strap_taken_ff;
    logic [4:0] phy_addr_ff;
    logic       st_loop_ff;
    logic       st_speed_ff;
    logic       st_an_ff;
    logic       st_duplex_ff;
    logic       st_iso_ff;

    // soft reset never comes here again, so the pins are not re-read
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            strap_taken_ff <= 1'b0;
            phy_addr_ff    <= 5'h00;
            st_loop_ff     <= 1'b0;
            st_speed_ff    <= 1'b0;
            st_an_ff       <= 1'b0;
            st_duplex_ff   <= 1'b0;
            st_iso_ff      <= 1'b0;
        end else if (!strap_taken_ff) begin
            strap_taken_ff <= 1'b1;
            phy_addr_ff    <= phy_addr_pin;
            st_loop_ff     <= pin_sync_ff[4];
            st_speed_ff    <= pin_sync_ff[5];
            st_an_ff       <= pin_sync_ff[6];
            st_duplex_ff   <= pin_sync_ff[7];
            st_iso_ff      <= (phy_addr_pin == `PBC_ISOLATE_ADDR);
        end
    end

    // ---------------------------------------------------------------
    // management frame receiver
    // ---------------------------------------------------------------
    pbc_mdio_state_t state_ff;
    pbc_mdio_state_t nxt_state;
    logic [5:0]  pre_cnt_ff;
    logic [4:0]  bit_cnt_ff;
    logic [12:0] hdr_ff;
    pbc_word_t   shift_ff;
    logic        wr_stb_ff;
    pbc_word_t   wr_data_ff;
    logic        mdio_out_ff;
    logic        mdio_oe_ff;

    // header after the start zero: st(1) op(2) phy(5) reg(5)
    wire [1:0] hdr_op   = hdr_ff[11:10];
    wire       hdr_ok   = hdr_ff[12] && (hdr_ff[9:5] == phy_addr_ff)
                          && (hdr_ff[4:0] == `PBC_REG_BASIC_CONTROL);
    wire       is_read  = hdr_ok && (hdr_op == `PBC_OP_READ);
    wire       is_write = hdr_ok && (hdr_op == `PBC_OP_WRITE);
    wire       pre_full = (pre_cnt_ff == `PBC_PREAMBLE_LEN);
    wire       last_bit = (bit_cnt_ff == `PBC_DATA_BITS - 5'h01);
    pbc_word_t ctrl_rd;

    // next state, advanced only on a management clock rising edge
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PBC_ST_IDLE: begin
                if (pre_full && !mdio_bit) nxt_state = PBC_ST_HDR;
            end
            PBC_ST_HDR: begin
                if (bit_cnt_ff == `PBC_HDR_BITS - 5'h01) nxt_state = PBC_ST_TA;
            end
            PBC_ST_TA: begin
                if (bit_cnt_ff == `PBC_TA_BITS - 5'h01) nxt_state = PBC_ST_DATA;
            end
            PBC_ST_DATA: begin
                if (last_bit) nxt_state = PBC_ST_IDLE;
            end
            default: nxt_state = PBC_ST_IDLE;
        endcase
    end

    // frames to other addresses or registers get no answer at all
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            state_ff    <= PBC_ST_IDLE;
            pre_cnt_ff  <= 6'h00;
            bit_cnt_ff  <= 5'h00;
            hdr_ff      <= 13'h0000;
            shift_ff    <= 16'h0000;
            wr_stb_ff   <= 1'b0;
            wr_data_ff  <= 16'h0000;
            mdio_out_ff <= 1'b0;
            mdio_oe_ff  <= 1'b0;
        end else begin
            wr_stb_ff <= 1'b0;
            if (mdc_rise) begin
                state_ff   <= nxt_state;
                bit_cnt_ff <= (nxt_state != state_ff) ? 5'h00 : bit_cnt_ff + 5'h01;
                if (state_ff == PBC_ST_IDLE) begin
                    pre_cnt_ff <= !mdio_bit ? 6'h00 :
                                  (pre_full ? pre_cnt_ff : pre_cnt_ff + 6'h01);
                end else begin
                    pre_cnt_ff <= 6'h00;
                end
                if (state_ff == PBC_ST_HDR) begin
                    hdr_ff <= {hdr_ff[11:0], mdio_bit};
                end
                if (state_ff == PBC_ST_TA && bit_cnt_ff == 5'h00 && is_read) begin
                    mdio_oe_ff  <= 1'b1; // second turnaround bit driven low
                    mdio_out_ff <= 1'b0;
                    shift_ff    <= ctrl_rd;
                end else if (state_ff == PBC_ST_TA && bit_cnt_ff != 5'h00 && is_read) begin
                    mdio_out_ff <= shift_ff[15];
                    shift_ff    <= {shift_ff[14:0], 1'b0};
                end else if (state_ff == PBC_ST_DATA) begin
                    if (is_read && !last_bit) begin
                        mdio_out_ff <= shift_ff[15];
                        shift_ff    <= {shift_ff[14:0], 1'b0};
                    end else begin
                        mdio_oe_ff  <= 1'b0;
                        mdio_out_ff <= 1'b0;
                        shift_ff    <= {shift_ff[14:0], mdio_bit};
                    end
                    if (last_bit && is_write) begin
                        wr_stb_ff  <= 1'b1;
                        wr_data_ff <= {shift_ff[14:0], mdio_bit};
                    end
                end
            end
        end
    end

    assign mdio_out    = mdio_out_ff;
    assign mdio_oe_out = mdio_oe_ff;

    // ---------------------------------------------------------------
    // basic control register
    // ---------------------------------------------------------------
    logic loop_ff;
    logic speed_ff;
    logic an_ff;
    logic an_wr_ff;
    logic pdown_ff;
    logic iso_ff;
    logic duplex_ff;
    logic coltest_ff;
    logic restart_ff;

    wire busy   = mode.sr_busy;
    // a write in the final busy cycle is lost to the reload anyway
    wire wr_ok  = wr_stb_ff && !busy;
    wire hw_off = !hw_an_pin || fibre_pin;
    wire an_eff = !hw_off && (an_wr_ff ? an_ff : st_an_ff);

    // soft reset completion reloads the latched straps
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            loop_ff    <= 1'b0;
            speed_ff   <= 1'b0;
            an_ff      <= 1'b0;
            an_wr_ff   <= 1'b0;
            pdown_ff   <= 1'b0;
            iso_ff     <= 1'b0;
            duplex_ff  <= 1'b0;
            coltest_ff <= 1'b0;
        end else if (!strap_taken_ff || mode.sr_done) begin
            loop_ff    <= strap_taken_ff ? st_loop_ff : pin_sync_ff[4];
            speed_ff   <= strap_taken_ff ? st_speed_ff : pin_sync_ff[5];
            an_ff      <= 1'b0;
            an_wr_ff   <= 1'b0;
            pdown_ff   <= 1'b0;
            iso_ff     <= strap_taken_ff ? st_iso_ff
                                         : (phy_addr_pin == `PBC_ISOLATE_ADDR);
            duplex_ff  <= strap_taken_ff ? st_duplex_ff : pin_sync_ff[7];
            coltest_ff <= 1'b0;
        end else if (wr_ok) begin
            loop_ff    <= wr_data_ff[`PBC_BIT_LOOPBACK];
            speed_ff   <= wr_data_ff[`PBC_BIT_SPEED];
            pdown_ff   <= wr_data_ff[`PBC_BIT_PDOWN];
            iso_ff     <= wr_data_ff[`PBC_BIT_ISOLATE];
            duplex_ff  <= wr_data_ff[`PBC_BIT_DUPLEX];
            coltest_ff <= wr_data_ff[`PBC_BIT_COLTEST];
            if (hw_an_pin) begin
                an_ff    <= wr_data_ff[`PBC_BIT_NEGOTIATION_HW_ENABLE_PIN];
                an_wr_ff <= 1'b1;
            end
        end
    end

    // restart pulse; a request with negotiation off is simply dropped
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            restart_ff <= 1'b0;
        end else begin
            restart_ff <= wr_ok && wr_data_ff[`PBC_BIT_RESTART] && an_eff;
        end
    end

    // single write of one starts the reset, zero is a no-op
    assign mode.sr_start = wr_ok && wr_data_ff[`PBC_BIT_SRESET];
    assign mode.loopback = loop_ff;
    assign mode.col_test = coltest_ff;

    // read image: restart and reserved bits are always zero
    assign ctrl_rd = {busy, loop_ff, speed_ff, an_wr_ff ? an_ff : 1'b1,
                      pdown_ff, iso_ff, 1'b0, duplex_ff, coltest_ff,
                      7'h00};

    // ---------------------------------------------------------------
    // mode outputs
    // ---------------------------------------------------------------
    assign an_enable_out       = an_eff;
    assign speed_100_out       = speed_ff && !an_eff;
    assign full_duplex_out     = duplex_ff && !an_eff;
    assign an_restart_out      = restart_ff;
    assign loopback_out        = loop_ff;
    assign power_down_out      = pdown_ff;
    assign pad_dir_force_out   = pdown_ff;
    assign mii_out_en_out      = !iso_ff;
    assign mii_in_ignore_out   = iso_ff;
    assign soft_reset_busy_out = busy;
    assign mii_col_out         = mode.col;

    pbc_soft_reset #(
        .SRESET_CYCLES (SRESET_CYCLES)
    ) u_sreset (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .mode       (mode)
    );

    pbc_col_test u_col (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .tx_en_in   (mii_tx_en_in),
        .mode       (mode)
    );

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_busy_blocks_wr: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        strap_taken_ff && busy && !mode.sr_done |=> $stable(loop_ff) && $stable(iso_ff))
        else $error("control bit changed during soft reset");
    a_an_off_forced: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        hw_off |-> !an_enable_out)
        else $error("negotiation enabled despite fibre or pin");
    a_restart_gated: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        wr_ok && !an_eff |=> !an_restart_out)
        else $error("restart issued with negotiation off");
    a_restart_pulse: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        wr_ok && wr_data_ff[`PBC_BIT_RESTART] && an_eff |=> an_restart_out ##1 !an_restart_out)
        else $error("restart not a single pulse");
    a_forced_mode: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        an_enable_out |-> !speed_100_out && !full_duplex_out)
        else $error("forced bits leaked while negotiating");
    a_read_image: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        ctrl_rd[`PBC_RSVD_MSB:0] == 7'h00 && !ctrl_rd[`PBC_BIT_RESTART]
        && ctrl_rd[`PBC_BIT_SRESET] == busy)
        else $error("read image wrong");
    a_loop_write: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        strap_taken_ff && wr_ok && !mode.sr_done
        |=> loop_ff == $past(wr_data_ff[`PBC_BIT_LOOPBACK]))
        else $error("loop-back write not stored");
    a_isolate_out: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        strap_taken_ff && wr_ok |=> mii_out_en_out == !$past(wr_data_ff[`PBC_BIT_ISOLATE])
        && ctrl_rd[`PBC_BIT_ISOLATE] == !mii_out_en_out)
        else $error("isolate read differs from MII state");
    a_pin_blocks_an: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        strap_taken_ff && !hw_an_pin |=> $stable(an_ff) || $past(mode.sr_done))
        else $error("negotiation bit written while pin low");
endmodule

// file: pbc_mdio_mgr.sv
`timescale 1ns/1ps
module pbc_mdio_mgr
    import pbc_pkg::*;
(
    input  wire logic clk_sys_in,
    input  wire logic dut_mdio_in,
    input  wire logic dut_oe_in,
    output logic      mdc_out,
    output logic      mdio_line_out
);
    logic drv_en;
    logic drv_bit;
    // ---------------------------------------------------------------
    // shared data line
    // ---------------------------------------------------------------
    // a released line floats to the pull-up, it never keeps the last bit
    assign mdio_line_out = dut_oe_in ? dut_mdio_in : (drv_en ? drv_bit : 1'b1);
    initial begin
        mdc_out = 1'b0;
        drv_en  = 1'b0;
        drv_bit = 1'b1;
    end
    // one clock of 8 system cycles; mdc idles low between frames
    task automatic tick(input logic b, output logic smp);
        drv_bit = b;
        repeat (4) @(posedge clk_sys_in);
        #1 smp = mdio_line_out;
        mdc_out = 1'b1;
        repeat (4) @(posedge clk_sys_in);
        #1 mdc_out = 1'b0;
    endtask
    // preamble, header, turnaround and 16 data bits msb first
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                         input pbc_word_t wd, output pbc_word_t rd);
        logic [31:0] bits;
        logic        s;
        bits = {2'h1, op, phy, 5'h00, 2'h2, wd};
        drv_en = 1'b1;
        repeat (32) tick(1'b1, s);
        for (int i = 31; i >= 0; i--) begin
            // hand the line over for the turnaround of a read
            if (op == 2'h2 && i == 17) drv_en = 1'b0;
            tick(bits[i], s);
            if (i < 16) rd[i] = s;
        end
        drv_en = 1'b0;
    endtask
endmodule

// file: test_phy_basic_control_register.sv
`timescale 1ns/1ps
`include "pbc_regs.svh"
module test_phy_basic_control_register
    import pbc_pkg::*;
;
    localparam int SR = 2000;
    logic       clk_sys_in, nrst_in, mdc, mdio_line, mdio_out, mdio_oe_out;
    logic [4:0] strap_phy_addr_in, addr;
    logic       strap_loopback_in, strap_speed_in, strap_negotiation_hw_enable_pin_in, strap_duplex_in;
    logic       fibre_mode_in, negotiation_hw_enable_pin_in, mii_tx_en_in, mii_col_out;
    logic       speed_100_out, full_duplex_out, an_enable_out, an_restart_out;
    logic       loopback_out, power_down_out, pad_dir_force_out, mii_out_en_out;
    logic       mii_in_ignore_out, soft_reset_busy_out;
    int         err_count, check_count, pulses, busy_cnt, cyc;

    pbc_top #(.SRESET_CYCLES(SR)) i_dut (.clk_sys_in, .nrst_in, .mdc_in(mdc),
        .mdio_in(mdio_line), .mdio_out, .mdio_oe_out, .strap_phy_addr_in,
        .strap_loopback_in, .strap_speed_in, .strap_negotiation_hw_enable_pin_in, .strap_duplex_in,
        .fibre_mode_in, .negotiation_hw_enable_pin_in, .mii_tx_en_in, .mii_col_out,
        .speed_100_out, .full_duplex_out, .an_enable_out, .an_restart_out,
        .loopback_out, .power_down_out, .pad_dir_force_out, .mii_out_en_out,
        .mii_in_ignore_out, .soft_reset_busy_out);
    pbc_mdio_mgr i_mgr (.clk_sys_in, .dut_mdio_in(mdio_out), .dut_oe_in(mdio_oe_out),
        .mdc_out(mdc), .mdio_line_out(mdio_line));

    // ---------------------------------------------------------------
    // clock, monitors and helpers
    // ---------------------------------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    // pulses and busy cycles are counted, so a short pulse is never missed
    always @(posedge clk_sys_in) begin
        cyc++;
        if (an_restart_out === 1'b1) pulses++;
        if (soft_reset_busy_out === 1'b1) busy_cnt++;
        if (cyc == 60000) begin
            err_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk_w(input pbc_word_t got, input pbc_word_t exp, input string m);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp, input string m);
        chk_w({15'h0000, got}, {15'h0000, exp}, m);
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    // synchronisers and strobe need about four cycles after the last edge
    task automatic wr(input pbc_word_t d);
        pbc_word_t r;
        i_mgr.frame(`PBC_OP_WRITE, addr, d, r);
        wait_clk(6);
    endtask
    task automatic rd_chk(input pbc_word_t e, input string m);
        pbc_word_t r;
        i_mgr.frame(`PBC_OP_READ, addr, 16'h0000, r);
        chk_w(r, e, m);
    endtask
    task automatic do_reset();
        nrst_in = 1'b0;
        wait_clk(3);
        nrst_in = 1'b1;
        wait_clk(3);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {nrst_in, mii_tx_en_in, fibre_mode_in, strap_loopback_in} = 4'h0;
        {strap_speed_in, strap_negotiation_hw_enable_pin_in, strap_duplex_in} = 3'h7;
        negotiation_hw_enable_pin_in = 1'b1;
        strap_phy_addr_in = 5'h01;
        addr = 5'h01;
        do_reset();
        rd_chk(16'h3100, "strap defaults");
        chk_b(speed_100_out, 1'b0, "speed while negotiating");
        wr(16'h217F);
        rd_chk(16'h2100, "reserved bits");
        chk_b(speed_100_out, 1'b1, "forced speed");
        chk_b(full_duplex_out, 1'b1, "forced duplex");
        wr(16'h2300);
        wr(16'h1100);
        chk_w(16'(pulses), 16'h0000, "stale restart");
        chk_b(full_duplex_out, 1'b0, "duplex masked");
        wr(16'h1200);
        chk_w(16'(pulses), 16'h0001, "restart pulse");
        rd_chk(16'h1000, "restart reads zero");
        negotiation_hw_enable_pin_in = 1'b0;
        wr(16'h0000);
        chk_b(an_enable_out, 1'b0, "pin disables");
        negotiation_hw_enable_pin_in = 1'b1;
        fibre_mode_in = 1'b1;
        rd_chk(16'h1000, "write under pin");
        chk_b(an_enable_out, 1'b0, "fibre disables");
        fibre_mode_in = 1'b0;
        wr(16'h4080);
        chk_b(loopback_out, 1'b1, "loopback on");
        mii_tx_en_in = 1'b1;
        wait_clk(6);
        chk_b(mii_col_out, 1'b1, "col rises");
        mii_tx_en_in = 1'b0;
        wait_clk(6);
        chk_b(mii_col_out, 1'b0, "col falls");
        wr(16'h0080);
        mii_tx_en_in = 1'b1;
        wait_clk(6);
        chk_b(mii_col_out, 1'b0, "col without loopback");
        mii_tx_en_in = 1'b0;
        wr(16'h0C00);
        chk_b(pad_dir_force_out, 1'b1, "power down");
        chk_b(power_down_out, 1'b1, "channel down");
        chk_b(mii_out_en_out, 1'b0, "isolate outputs");
        chk_b(mii_in_ignore_out, 1'b1, "isolate inputs");
        rd_chk(16'h0C00, "isolate reads");
        wr(16'h0000);
        chk_b(mii_out_en_out, 1'b1, "isolate cleared");
        strap_speed_in = 1'b0;
        wr(16'h8000);
        rd_chk(16'h8000, "reset bit reads one");
        wr(16'h4000);
        chk_b(loopback_out, 1'b0, "write while busy");
        for (int n = 0; n < 3000 && soft_reset_busy_out !== 1'b0; n++) wait_clk(1);
        chk_w(16'(busy_cnt), 16'(SR), "busy length");
        rd_chk(16'h3100, "no re-strap");
        wr(16'h0000);
        strap_phy_addr_in = 5'h00;
        addr = 5'h00;
        do_reset();
        rd_chk(16'h1500, "zero address isolates");
        chk_b(mii_out_en_out, 1'b0, "isolated at start");
        chk_b(an_enable_out, 1'b1, "negotiation from strap");
        test_done();
    end
endmodule
